// File: rtl/uhpc_pkg.sv
// package: register map, field layout, states and timing for the host pipe control block
package uhpc_pkg;
  // ****************************************
  // register offsets
  // ****************************************
  localparam logic [3:0] OFS_CTRL = 4'h0;
  localparam logic [3:0] OFS_HCMD = 4'h1;
  localparam logic [3:0] OFS_HSTAT = 4'h2;
  localparam logic [3:0] OFS_HADDR = 4'h3;
  localparam logic [3:0] OFS_PSEL = 4'h4;
  localparam logic [3:0] OFS_PEN = 4'h5;
  localparam logic [3:0] OFS_PCFG = 4'h6;
  localparam logic [3:0] OFS_PSIZE = 4'h7;
  localparam logic [3:0] OFS_PINTV = 4'h8;
  localparam logic [3:0] OFS_STATE = 4'h9;
  // ****************************************
  // bit positions
  // ****************************************
  localparam int CTRL_ENABLE = 0;
  localparam int CTRL_HOST = 1;
  localparam int CTRL_DETACH = 2;
  localparam int CTRL_VBUS = 3;
  localparam int HCMD_RESET = 0;
  localparam int HCMD_SOF = 1;
  localparam int HCMD_RSTIE = 2;
  localparam int HST_RSTDONE = 0;
  localparam int HST_WAKEUP = 1;
  localparam int HST_CONN = 2;
  localparam int HST_DISC = 3;
  localparam int PSEL_OWNER = 6;
  localparam int PSEL_FLOW = 7;
  localparam int PEN_ENABLE = 0;
  localparam int PEN_READY = 1;
  localparam int PCFG_OK = 7;
  // ****************************************
  // reset values and codes
  // ****************************************
  localparam logic [7:0] CTRL_RST = 8'h04;
  localparam logic [1:0] TYPE_CONTROL = 2'h0;
  localparam logic [1:0] BANKS_ONE = 2'h0;
  localparam logic [1:0] TOKEN_SETUP = 2'h0;
  // ****************************************
  // timing: bus reset length
  // ****************************************
  localparam int CLK_MHZ = 40;
  localparam int BUS_RESET_US = 10000;
  localparam int BUS_RESET_CYC = BUS_RESET_US * CLK_MHZ;

  typedef enum logic [1:0] {
    ST_RESET,
    ST_IDLE,
    ST_READY,
    ST_SUSPEND
  } uhpc_state_type;

  // per-pipe configuration
  typedef struct packed {
    logic en;
    logic ok;
    logic [1:0] ptype;
    logic [1:0] token;
    logic [1:0] banks;
    logic [2:0] size;
    logic [7:0] intv;
  } uhpc_pipe_type;

  // register port request
  typedef struct packed {
    logic wr;
    logic rd;
    logic [3:0] addr;
    logic [7:0] wdata;
  } uhpc_req_type;
endpackage

// File: rtl/uhpc_top.sv
// host pipe control: states, attach, pipe select, pipe config, bus reset, address
// ****************************************
// Notes on behaviour
// R1 - detach bit resets to one
// R2 - reset state, then idle when host enabled
// R3 - suspend whenever frames are not generated
// R4 - connect when line leaves SE0 with power
// R5 - disconnect when line returns to SE0
// R6 - firmware clears owner, writes pipe index
// R7 - flow controller accesses only after flow_ready
// R8 - two pipe index registers muxed by owner
// R9 - clearing flow_ready freezes, setting resumes
// R10 - enabled valid pipe is ready for requests
// R11 - valid config: only token, interval change
// R12 - control pipe needs one bank
// R13 - disabling pipe restores its reset values
// R14 - firmware sets default pipe then resizes; the code ignores PSIZE writes while the pipe is valid
// R15 - reset command drives reset, sets done flag
// R16 - bus reset clears pipes, keeps irq enable
// R17 - reset from suspend wakes and starts frames
// R18 - written address used for all pipes
// R19 - bus reset clears target address
// R20 - clearing frame enable enters suspend
// R21 - held flow request keeps pipe state
// ****************************************
//
// The address map and the strobed register port are this design's own decisions.
`timescale 1ns/10ps
module uhpc_top #(
  parameter int NPIPE = 7,
  parameter int RESET_CYCLES = uhpc_pkg::BUS_RESET_CYC
) (
  // clock and reset
  input wire logic clock,
  input wire logic rst_n,
  // register port
  input wire uhpc_pkg::uhpc_req_type req,
  output logic [7:0] rdata_ff,
  // usb line
  input wire logic line_dp,
  input wire logic line_dm,
  output logic vbus_drive_ff,
  output logic bus_reset_drive_ff,
  output logic sof_run_ff,
  output logic [6:0] target_addr_ff,
  output logic reset_irq_ff,
  // data flow controller
  input wire logic flow_req,
  output logic flow_grant_ff,
  output logic [2:0] flow_pipe_ff,
  output logic pipe_ready_ff
);
  localparam int CW = $clog2(RESET_CYCLES + 1);

  logic [7:0] ctrl_ff;
  logic sof_ff, rstie_ff, rstcmd_ff;
  logic [3:0] flags_ff;
  logic owner_ff, flow_ready_ff;
  logic [2:0] cpu_pipe_ff, dfc_pipe_ff;
  logic [CW-1:0] rcnt_ff;
  uhpc_pkg::uhpc_state_type state_ff, nxt_state;
  uhpc_pkg::uhpc_pipe_type pipe_ff [NPIPE];
  logic se0, powered, host_on, reset_end;
  logic cpu_live, dfc_live;
  logic [3:0] nxt_flags;

  function automatic logic hit(input uhpc_pkg::uhpc_req_type r, input logic [3:0] ofs);
    hit = r.wr && (r.addr == ofs);
  endfunction

  // control bits must be valid as configured: one bank for control pipes
  function automatic logic cfg_check(input logic [1:0] t, input logic [1:0] b);
    cfg_check = (t != uhpc_pkg::TYPE_CONTROL) || (b == uhpc_pkg::BANKS_ONE); // see R12
  endfunction

  assign se0 = !line_dp && !line_dm;
  assign powered = ctrl_ff[uhpc_pkg::CTRL_VBUS];
  assign host_on = ctrl_ff[uhpc_pkg::CTRL_ENABLE] && ctrl_ff[uhpc_pkg::CTRL_HOST]
                   && !ctrl_ff[uhpc_pkg::CTRL_DETACH];
  assign reset_end = rstcmd_ff && (rcnt_ff == CW'(RESET_CYCLES - 1));
  // an index past the last pipe names no pipe, so it never counts as live
  assign cpu_live = (int'(cpu_pipe_ff) < NPIPE) && pipe_ff[cpu_pipe_ff].en && pipe_ff[cpu_pipe_ff].ok;
  assign dfc_live = (int'(dfc_pipe_ff) < NPIPE) && pipe_ff[dfc_pipe_ff].en && pipe_ff[dfc_pipe_ff].ok;

  // ****************************************
  // general control
  // ****************************************
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      ctrl_ff <= uhpc_pkg::CTRL_RST; // see R1
    end else if (hit(req, uhpc_pkg::OFS_CTRL)) begin
      ctrl_ff <= {4'h0, req.wdata[3:0]};
    end
  end

  // ****************************************
  // host state machine
  // ****************************************
  always_comb begin
    nxt_state = state_ff;
    case (state_ff)
      uhpc_pkg::ST_RESET: begin
        if (host_on) begin
          nxt_state = uhpc_pkg::ST_IDLE; // see R2
        end
      end
      uhpc_pkg::ST_IDLE: begin
        if (powered && !se0) begin
          nxt_state = sof_ff ? uhpc_pkg::ST_READY : uhpc_pkg::ST_SUSPEND; // see R4
        end
      end
      uhpc_pkg::ST_READY, uhpc_pkg::ST_SUSPEND: begin
        if (se0 && !rstcmd_ff) begin
          nxt_state = uhpc_pkg::ST_IDLE; // see R5
        end else begin
          nxt_state = sof_ff ? uhpc_pkg::ST_READY : uhpc_pkg::ST_SUSPEND; // see R3 R20
        end
      end
      default: nxt_state = uhpc_pkg::ST_RESET;
    endcase
    if (!host_on) begin
      nxt_state = uhpc_pkg::ST_RESET;
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      state_ff <= uhpc_pkg::ST_RESET;
    end else begin
      state_ff <= nxt_state;
    end
  end

  // ****************************************
  // bus reset command and frame enable
  // ****************************************
  // the command bit stays high until the reset has gone out on the line
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      rstcmd_ff <= 1'b0;
      rcnt_ff <= '0;
    end else if (reset_end) begin
      rstcmd_ff <= 1'b0;
      rcnt_ff <= '0;
    end else if (rstcmd_ff) begin
      rcnt_ff <= rcnt_ff + CW'(1); // see R15
    end else if (hit(req, uhpc_pkg::OFS_HCMD) && req.wdata[uhpc_pkg::HCMD_RESET]) begin
      rstcmd_ff <= 1'b1; // see R15
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      sof_ff <= 1'b0;
      rstie_ff <= 1'b0;
    end else begin
      if (hit(req, uhpc_pkg::OFS_HCMD)) begin
        rstie_ff <= req.wdata[uhpc_pkg::HCMD_RSTIE]; // see R16
      end
      if (reset_end) begin
        sof_ff <= 1'b1; // see R17
      end else if (hit(req, uhpc_pkg::OFS_HCMD)) begin
        sof_ff <= req.wdata[uhpc_pkg::HCMD_SOF]; // see R20
      end
    end
  end

  // ****************************************
  // status flags, write one to clear, set wins
  // ****************************************
  always_comb begin
    nxt_flags = flags_ff;
    if (hit(req, uhpc_pkg::OFS_HSTAT)) begin
      nxt_flags = flags_ff & ~req.wdata[3:0];
    end
    if (reset_end) begin
      nxt_flags[uhpc_pkg::HST_RSTDONE] = 1'b1; // see R15
      if (!sof_ff) begin
        nxt_flags[uhpc_pkg::HST_WAKEUP] = 1'b1; // see R17
      end
    end
    if (state_ff == uhpc_pkg::ST_IDLE && nxt_state != uhpc_pkg::ST_IDLE && host_on) begin
      nxt_flags[uhpc_pkg::HST_CONN] = 1'b1; // see R4
    end
    if ((state_ff == uhpc_pkg::ST_READY || state_ff == uhpc_pkg::ST_SUSPEND) && nxt_state == uhpc_pkg::ST_IDLE) begin
      nxt_flags[uhpc_pkg::HST_DISC] = 1'b1; // see R5
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      flags_ff <= 4'h0;
    end else begin
      flags_ff <= nxt_flags;
    end
  end

  // ****************************************
  // target address
  // ****************************************
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      target_addr_ff <= 7'h00;
    end else if (reset_end) begin
      target_addr_ff <= 7'h00; // see R19
    end else if (hit(req, uhpc_pkg::OFS_HADDR)) begin
      target_addr_ff <= req.wdata[6:0]; // see R18
    end
  end

  // ****************************************
  // pipe selection: two indices behind one field
  // ****************************************
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      owner_ff <= 1'b0;
      flow_ready_ff <= 1'b0;
      cpu_pipe_ff <= 3'h0;
      dfc_pipe_ff <= 3'h0;
    end else if (hit(req, uhpc_pkg::OFS_PSEL)) begin
      owner_ff <= req.wdata[uhpc_pkg::PSEL_OWNER];
      flow_ready_ff <= req.wdata[uhpc_pkg::PSEL_FLOW]; // see R7 R9
      if (req.wdata[uhpc_pkg::PSEL_OWNER]) begin
        dfc_pipe_ff <= req.wdata[2:0]; // see R8
      end else begin
        cpu_pipe_ff <= req.wdata[2:0]; // see R6 R8
      end
    end
  end

  // ****************************************
  // pipe configuration, one set per pipe
  // ****************************************
  // pipe registers are reached through the cpu index only
  for (genvar p = 0; p < NPIPE; p++) begin : g_pipe
    logic sel;
    assign sel = (cpu_pipe_ff == 3'(p));
    always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
        pipe_ff[p] <= '0;
      end else if (reset_end) begin
        pipe_ff[p] <= '0; // see R16
      end else if (sel && hit(req, uhpc_pkg::OFS_PEN)) begin
        if (!req.wdata[uhpc_pkg::PEN_ENABLE]) begin
          pipe_ff[p] <= '0; // see R13
        end else begin
          pipe_ff[p].en <= 1'b1;
          pipe_ff[p].ok <= cfg_check(pipe_ff[p].ptype, pipe_ff[p].banks); // see R12
        end
      end else if (sel && hit(req, uhpc_pkg::OFS_PCFG)) begin
        pipe_ff[p].token <= req.wdata[3:2]; // see R11
        if (!pipe_ff[p].ok) begin
          pipe_ff[p].banks <= req.wdata[1:0];
          pipe_ff[p].ptype <= req.wdata[5:4];
        end
      end else if (sel && hit(req, uhpc_pkg::OFS_PSIZE) && !pipe_ff[p].ok) begin
        pipe_ff[p].size <= req.wdata[2:0]; // see R11
      end else if (sel && hit(req, uhpc_pkg::OFS_PINTV)) begin
        pipe_ff[p].intv <= req.wdata; // see R11
      end
    end
  end

  // ****************************************
  // flow controller access
  // ****************************************
  // a request that arrives while flow_ready is low is simply held by the
  // requester; nothing in the pipe is touched, so the transfer resumes intact
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      flow_grant_ff <= 1'b0;
      flow_pipe_ff <= 3'h0;
    end else begin
      flow_pipe_ff <= dfc_pipe_ff;
      flow_grant_ff <= flow_req && flow_ready_ff && owner_ff && dfc_live; // see R7 R9 R21
    end
  end

  // ****************************************
  // line and status outputs
  // ****************************************
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      vbus_drive_ff <= 1'b0;
      bus_reset_drive_ff <= 1'b0;
      sof_run_ff <= 1'b0;
      reset_irq_ff <= 1'b0;
      pipe_ready_ff <= 1'b0;
    end else begin
      vbus_drive_ff <= powered && host_on; // see R4
      bus_reset_drive_ff <= rstcmd_ff && !reset_end; // see R15
      sof_run_ff <= sof_ff && !rstcmd_ff && (state_ff == uhpc_pkg::ST_READY); // see R3 R20
      reset_irq_ff <= nxt_flags[uhpc_pkg::HST_RSTDONE] && rstie_ff; // see R15
      pipe_ready_ff <= cpu_live && (state_ff == uhpc_pkg::ST_READY); // see R10
    end
  end

  // ****************************************
  // register read, data in the following cycle
  // ****************************************
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      rdata_ff <= 8'h00;
    end else if (req.rd) begin
      case (req.addr)
        uhpc_pkg::OFS_CTRL: rdata_ff <= ctrl_ff;
        uhpc_pkg::OFS_HCMD: rdata_ff <= {5'h00, rstie_ff, sof_ff, rstcmd_ff};
        uhpc_pkg::OFS_HSTAT: rdata_ff <= {4'h0, flags_ff};
        uhpc_pkg::OFS_HADDR: rdata_ff <= {1'b0, target_addr_ff};
        uhpc_pkg::OFS_PSEL: rdata_ff <= {flow_ready_ff, owner_ff, 3'h0,
                                         owner_ff ? dfc_pipe_ff : cpu_pipe_ff}; // see R8
        uhpc_pkg::OFS_PEN: rdata_ff <= {6'h00, pipe_ff[cpu_pipe_ff].ok, pipe_ff[cpu_pipe_ff].en};
        uhpc_pkg::OFS_PCFG: rdata_ff <= {pipe_ff[cpu_pipe_ff].ok, 1'b0, pipe_ff[cpu_pipe_ff].ptype,
                                         pipe_ff[cpu_pipe_ff].token, pipe_ff[cpu_pipe_ff].banks};
        uhpc_pkg::OFS_PSIZE: rdata_ff <= {5'h00, pipe_ff[cpu_pipe_ff].size};
        uhpc_pkg::OFS_PINTV: rdata_ff <= pipe_ff[cpu_pipe_ff].intv;
        uhpc_pkg::OFS_STATE: rdata_ff <= {4'h0, line_dp, line_dm, 2'(state_ff)};
        default: rdata_ff <= 8'h00;
      endcase
    end else begin
      rdata_ff <= 8'h00;
    end
  end

  // ****************************************
  // assertions
  // ****************************************
  default clocking @(posedge clock); endclocking
  default disable iff (!rst_n);

  detach_reset_a: assert property ($rose(rst_n) |-> ctrl_ff[uhpc_pkg::CTRL_DETACH]) // see R1
    else $error("detach bit not set after reset");
  idle_entry_a: assert property (state_ff == uhpc_pkg::ST_RESET && host_on // see R2
    |=> state_ff == uhpc_pkg::ST_IDLE)
    else $error("no idle after host enable");
  suspend_sof_a: assert property (state_ff == uhpc_pkg::ST_READY && host_on && !sof_ff && !se0 // see R3
    |=> state_ff == uhpc_pkg::ST_SUSPEND)
    else $error("no suspend with frames off");
  connect_det_a: assert property (state_ff == uhpc_pkg::ST_IDLE && host_on && powered && !se0 // see R4
    |=> flags_ff[uhpc_pkg::HST_CONN])
    else $error("connection missed");
  disc_det_a: assert property (state_ff == uhpc_pkg::ST_READY && se0 && !rstcmd_ff && host_on // see R5
    |=> state_ff == uhpc_pkg::ST_IDLE ##0 flags_ff[uhpc_pkg::HST_DISC])
    else $error("disconnection missed");
  flow_gate_a: assert property (!flow_ready_ff |=> !flow_grant_ff) // see R9
    else $error("grant while flow frozen");
  ctrl_bank_a: assert property (pipe_ff[cpu_pipe_ff].ok && pipe_ff[cpu_pipe_ff].ptype == uhpc_pkg::TYPE_CONTROL
    |-> pipe_ff[cpu_pipe_ff].banks == uhpc_pkg::BANKS_ONE) // see R12
    else $error("control pipe valid with many banks");
  cfg_lock_a: assert property (pipe_ff[cpu_pipe_ff].ok && !reset_end && !hit(req, uhpc_pkg::OFS_PEN) // see R11
    && !hit(req, uhpc_pkg::OFS_PSEL)
    |=> $stable(pipe_ff[cpu_pipe_ff].size) && $stable(pipe_ff[cpu_pipe_ff].banks))
    else $error("size changed on valid pipe");
  pipe_clear_a: assert property (hit(req, uhpc_pkg::OFS_PEN) && !req.wdata[uhpc_pkg::PEN_ENABLE] // see R13
    && !reset_end && int'(cpu_pipe_ff) < NPIPE |=> pipe_ff[cpu_pipe_ff] == '0)
    else $error("disabled pipe kept config");
  reset_done_a: assert property (reset_end |=> flags_ff[uhpc_pkg::HST_RSTDONE] && target_addr_ff == 7'h00
    && sof_ff && !bus_reset_drive_ff) // see R15 R17 R19
    else $error("bus reset end effects missing");
  reset_wake_a: assert property (reset_end && !sof_ff |=> flags_ff[uhpc_pkg::HST_WAKEUP]) // see R17
    else $error("no wake-up after reset from suspend");
  irq_en_kept_a: assert property (reset_end && !hit(req, uhpc_pkg::OFS_HCMD) |=> $stable(rstie_ff)) // see R16
    else $error("irq enable changed by bus reset");
  reset_drive_a: assert property (rstcmd_ff && !reset_end |=> bus_reset_drive_ff) // see R15
    else $error("bus reset not driven");
  addr_load_a: assert property (hit(req, uhpc_pkg::OFS_HADDR) && !reset_end // see R18
    |=> target_addr_ff == $past(req.wdata[6:0]))
    else $error("written address not used");
  frame_stop_a: assert property (!sof_ff |=> !sof_run_ff) // see R3 R20
    else $error("frames run with frame enable clear");
  vbus_need_a: assert property (!powered |=> !vbus_drive_ff) // see R4
    else $error("supply driven while disabled");

  reset_cycle_c: cover property (rstcmd_ff ##1 reset_end ##1 flags_ff[uhpc_pkg::HST_RSTDONE]);
  attach_c: cover property (state_ff == uhpc_pkg::ST_IDLE ##1 state_ff == uhpc_pkg::ST_READY);
  suspend_c: cover property (state_ff == uhpc_pkg::ST_READY ##1 state_ff == uhpc_pkg::ST_SUSPEND);
  flow_c: cover property (flow_grant_ff ##1 !flow_ready_ff);
  wake_c: cover property (reset_end && !sof_ff ##1 flags_ff[uhpc_pkg::HST_WAKEUP]);
endmodule

// File: testbench/uhpc_dev_model.sv
// partner model: usb device on the host port, pull-up and attach
`timescale 1ns/10ps
module uhpc_dev_model (
  // control
  input wire logic attached,
  input wire logic vbus,
  input wire logic host_se0,
  // bus lines
  output logic dp,
  output logic dm
);
  // pull-up needs supply; otherwise the host pull-downs leave se0
  assign dp = attached & vbus & ~host_se0;
  assign dm = 1'b0;
endmodule

// File: testbench/tb_top.sv
// testbench: register sequences against the host pipe control block
`timescale 1ns/10ps
module tb_top;
  logic clock;
  logic rst_n;
  uhpc_pkg::uhpc_req_type req;
  logic [7:0] rdata_ff;
  logic line_dp, line_dm, vbus, rst_drv, sof, irq, flow_req, grant, ready, attached;
  logic [6:0] taddr;
  logic [2:0] fpipe;
  int fails = 0;
  int check_count = 0;

  uhpc_top #(.NPIPE(7), .RESET_CYCLES(8)) u_uhpc_top (
    .clock(clock), .rst_n(rst_n), .req(req), .rdata_ff(rdata_ff),
    .line_dp(line_dp), .line_dm(line_dm), .vbus_drive_ff(vbus),
    .bus_reset_drive_ff(rst_drv), .sof_run_ff(sof), .target_addr_ff(taddr),
    .reset_irq_ff(irq), .flow_req(flow_req), .flow_grant_ff(grant),
    .flow_pipe_ff(fpipe), .pipe_ready_ff(ready)
  );

  uhpc_dev_model u_uhpc_dev_model (
    .attached(attached), .vbus(vbus), .host_se0(rst_drv), .dp(line_dp), .dm(line_dm)
  );

  initial begin
    clock = 1'b0;
    forever #12.5 clock = ~clock;
  end

  // ****************************************
  // access and compare tasks
  // ****************************************
  task automatic chk(input string name, input logic [7:0] exp, input logic [7:0] got);
    check_count++;
    if (got !== exp) begin
      fails++;
      $display("MISMATCH %s expected %h seen %h", name, exp, got);
    end
  endtask

  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge clock);
    req.wr <= 1'b1;
    req.addr <= a;
    req.wdata <= d;
    @(posedge clock);
    req.wr <= 1'b0;
    #1;
  endtask

  task automatic rd(input logic [3:0] a, output logic [7:0] d);
    @(posedge clock);
    req.rd <= 1'b1;
    req.addr <= a;
    @(posedge clock);
    req.rd <= 1'b0;
    #1;
    d = rdata_ff;
  endtask

  // rereads a bounded number of times, since line sampling adds latency
  task automatic expect_reg(input string name, input logic [3:0] a, input logic [7:0] m,
                            input logic [7:0] e);
    logic [7:0] d;
    int n;
    n = 0;
    rd(a, d);
    while (((d & m) !== e) && n < 20) begin
      rd(a, d);
      n++;
    end
    chk(name, e, d & m);
  endtask

  task automatic bus_reset(input logic [7:0] cmd);
    int n;
    n = 0;
    wr(uhpc_pkg::OFS_HCMD, cmd);
    while (rst_drv !== 1'b1 && n < 8) begin
      @(posedge clock);
      #1;
      n++;
    end
    chk("drive_on", 8'h01, {7'h00, rst_drv});
    n = 0;
    while (rst_drv !== 1'b0 && n < 40) begin
      @(posedge clock);
      #1;
      n++;
    end
    chk("drive_off", 8'h00, {7'h00, rst_drv});
  endtask

  task automatic settle2;
    repeat (2) @(posedge clock);
    #1;
  endtask

  task automatic stop_test;
    $display("checks %0d mismatches %0d", check_count, fails);
    if (fails == 0 && check_count > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  initial begin
    repeat (8000) @(posedge clock);
    fails++;
    stop_test;
  end

  // ****************************************
  // main sequence
  // ****************************************
  initial begin
    req = '0;
    rst_n = 1'b0;
    attached = 1'b0;
    flow_req = 1'b0;
    repeat (12) @(posedge clock);
    rst_n <= 1'b1;
    expect_reg("ctrl_rst", uhpc_pkg::OFS_CTRL, 8'hFF, 8'h04);
    expect_reg("st_reset", uhpc_pkg::OFS_STATE, 8'h03, 8'h00);
    expect_reg("unmapped", 4'hF, 8'hFF, 8'h00);
    wr(uhpc_pkg::OFS_CTRL, 8'h07);
    expect_reg("st_detach", uhpc_pkg::OFS_STATE, 8'h03, 8'h00);
    wr(uhpc_pkg::OFS_CTRL, 8'h03);
    expect_reg("st_idle", uhpc_pkg::OFS_STATE, 8'h03, 8'h01);
    @(posedge clock);
    attached <= 1'b1;
    repeat (4) @(posedge clock);
    expect_reg("no_power", uhpc_pkg::OFS_HSTAT, 8'h04, 8'h00);
    wr(uhpc_pkg::OFS_CTRL, 8'h0B);
    settle2;
    chk("vbus", 8'h01, {7'h00, vbus});
    expect_reg("connect", uhpc_pkg::OFS_HSTAT, 8'h04, 8'h04);
    expect_reg("st_susp", uhpc_pkg::OFS_STATE, 8'h0F, 8'h0B);
    wr(uhpc_pkg::OFS_HSTAT, 8'hFF);
    expect_reg("w1c", uhpc_pkg::OFS_HSTAT, 8'h0F, 8'h00);
    wr(uhpc_pkg::OFS_HCMD, 8'h02);
    expect_reg("st_ready", uhpc_pkg::OFS_STATE, 8'h03, 8'h02);
    chk("sof_on", 8'h01, {7'h00, sof});
    wr(uhpc_pkg::OFS_HCMD, 8'h00);
    expect_reg("st_stop", uhpc_pkg::OFS_STATE, 8'h03, 8'h03);
    chk("sof_off", 8'h00, {7'h00, sof});
    wr(uhpc_pkg::OFS_HCMD, 8'h02);
    wr(uhpc_pkg::OFS_HADDR, 8'h05);
    chk("addr", 8'h05, {1'b0, taddr});
    // default control pipe: one bank, setup token
    wr(uhpc_pkg::OFS_PSEL, 8'h00);
    wr(uhpc_pkg::OFS_PCFG, 8'h00);
    wr(uhpc_pkg::OFS_PSIZE, 8'h03);
    wr(uhpc_pkg::OFS_PEN, 8'h01);
    expect_reg("p0_en", uhpc_pkg::OFS_PEN, 8'h03, 8'h03);
    chk("p0_ready", 8'h01, {7'h00, ready});
    wr(uhpc_pkg::OFS_PCFG, 8'h24);
    expect_reg("p0_lock", uhpc_pkg::OFS_PCFG, 8'hFF, 8'h84);
    wr(uhpc_pkg::OFS_PINTV, 8'h20);
    expect_reg("p0_intv", uhpc_pkg::OFS_PINTV, 8'hFF, 8'h20);
    wr(uhpc_pkg::OFS_PSIZE, 8'h05);
    expect_reg("p0_size", uhpc_pkg::OFS_PSIZE, 8'h07, 8'h03);
    // control pipe with two banks must not validate
    wr(uhpc_pkg::OFS_PSEL, 8'h01);
    wr(uhpc_pkg::OFS_PCFG, 8'h01);
    wr(uhpc_pkg::OFS_PEN, 8'h01);
    expect_reg("p1_bad", uhpc_pkg::OFS_PEN, 8'h03, 8'h01);
    wr(uhpc_pkg::OFS_PEN, 8'h00);
    expect_reg("p1_off", uhpc_pkg::OFS_PCFG, 8'hFF, 8'h00);
    // bulk pipe 2 handed to the flow controller
    wr(uhpc_pkg::OFS_PSEL, 8'h02);
    wr(uhpc_pkg::OFS_PCFG, 8'h20);
    wr(uhpc_pkg::OFS_PEN, 8'h01);
    wr(uhpc_pkg::OFS_PSEL, 8'h42);
    @(posedge clock);
    flow_req <= 1'b1;
    settle2;
    chk("grant_wait", 8'h00, {7'h00, grant});
    wr(uhpc_pkg::OFS_PSEL, 8'hC2);
    settle2;
    chk("grant_on", 8'h01, {7'h00, grant});
    chk("flow_pipe", 8'h02, {5'h00, fpipe});
    expect_reg("psel_flow", uhpc_pkg::OFS_PSEL, 8'hFF, 8'hC2);
    wr(uhpc_pkg::OFS_PSEL, 8'h00);
    settle2;
    chk("grant_frozen", 8'h00, {7'h00, grant});
    chk("pipe_kept", 8'h02, {5'h00, fpipe});
    expect_reg("psel_cpu", uhpc_pkg::OFS_PSEL, 8'hFF, 8'h00);
    wr(uhpc_pkg::OFS_PSEL, 8'hC2);
    settle2;
    chk("grant_resume", 8'h01, {7'h00, grant});
    @(posedge clock);
    flow_req <= 1'b0;
    // bus reset while frames run, irq enabled
    bus_reset(8'h07);
    expect_reg("rst_done", uhpc_pkg::OFS_HSTAT, 8'h03, 8'h01);
    chk("irq_on", 8'h01, {7'h00, irq});
    chk("addr_clr", 8'h00, {1'b0, taddr});
    expect_reg("hcmd_kept", uhpc_pkg::OFS_HCMD, 8'h07, 8'h06);
    expect_reg("pipes_clr", uhpc_pkg::OFS_PEN, 8'h03, 8'h00);
    wr(uhpc_pkg::OFS_HSTAT, 8'hFF);
    // bus reset from suspend, irq disabled
    bus_reset(8'h01);
    expect_reg("wake", uhpc_pkg::OFS_HSTAT, 8'h03, 8'h03);
    expect_reg("sof_set", uhpc_pkg::OFS_HCMD, 8'h02, 8'h02);
    chk("sof_run", 8'h01, {7'h00, sof});
    chk("irq_masked", 8'h00, {7'h00, irq});
    @(posedge clock);
    attached <= 1'b0;
    expect_reg("disconnect", uhpc_pkg::OFS_HSTAT, 8'h08, 8'h08);
    stop_test;
  end
endmodule
